// file: hdl/latched_flag_field.sv
// Latched status flags of a four-channel transceiver module, read and
// cleared over the two-wire management port; drives the interrupt request.
// Assumes condition and mask inputs come from logic on the core clock;
// the two-wire lines and the module reset pin are asynchronous.
// Behaviour
// R1: Bytes 3 to 21 form the flag field
// R2: Flags read zero without their condition
// R3: Defined conditions set their flag bits
// R4: Flags stay set until read clears them
// R5: Module reset pin clears all flags
// R6: Persistent condition may re-set flag immediately
// R7: Host tolerates interrupt glitch or steady assertion
// R8: Masked flags latch but raise no interrupt
// R9: Byte 3 holds transmit/receive signal loss
// R10: Byte 4 holds transmit faults; rest reserved
// R11: Byte 6 holds temperature alarms and warnings
// R12: Init-complete bit set after reset, read-cleared
// R13: Byte 7 supply voltage flags; byte 8 vendor
// R14: Byte 9 holds receive power channels 1,2
// R15: Interrupt low while any unmasked flag set
// R16: Clear only transferred bytes; never lose events
`timescale 1ns/1ps
module latched_flag_field #(
   parameter logic [6:0] DEVICE_ADDR = flag_field_pkg::DEVICE_ADDR_DEFAULT
) (
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   input wire logic I_MODULE_RESET_N,
   input wire logic I_SCL,
   input wire logic I_SDA,
   output logic O_SDA,
   output logic O_SDA_OE,
   input wire logic [3:0] I_TX_LOSS,
   input wire logic [3:0] I_RX_LOSS,
   input wire logic [3:0] I_TX_FAULT,
   input wire logic [3:0] I_TEMP_COND,
   input wire logic [3:0] I_VCC_COND,
   input wire logic [3:0] I_RX_POWER_CH1,
   input wire logic [3:0] I_RX_POWER_CH2,
   input wire logic I_INIT_DONE,
   input wire logic [7:0] I_VENDOR_FLAGS,
   input wire logic [7:0] I_MASK_SIGNAL_LOSS,
   input wire logic [7:0] I_MASK_TX_FAULT,
   input wire logic [7:0] I_MASK_TEMPERATURE,
   input wire logic [7:0] I_MASK_SUPPLY_VOLTAGE,
   input wire logic [7:0] I_MASK_RX_POWER,
   output logic O_INTERRUPT_REQUEST_N
);

   // Two-wire port states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_PTR,
      ST_PTR_ACK,
      ST_WDATA,
      ST_RDATA,
      ST_RDATA_ACK
   } port_state_e;

   // Latch update: set wins over clear so no event is lost
   function automatic logic [7:0] latch_next(input logic [7:0] cur, input logic [7:0] set,
                                             input logic [7:0] clr, input logic [7:0] impl);
      latch_next = ((cur & ~clr) | set) & impl;
   endfunction

   // Bits to clear in one register: only those the host actually received
   function automatic logic [7:0] clear_for(input logic fire, input logic [7:0] ptr,
                                            input logic [7:0] off, input logic [7:0] snap);
      clear_for = (fire && ptr == off) ? snap : 8'h00;
   endfunction

   // Synchroniser chains; first stage feeds only the second
   logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
   logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
   logic rstn_s1_reg, rstn_s2_reg;

   // Two-wire protocol state
   port_state_e state_reg;
   logic [2:0] bit_cnt_reg; // Bit position within the byte
   logic byte_full_reg; // Eighth bit has been clocked
   logic [7:0] rx_shift_reg; // Incoming bits
   logic [7:0] tx_shift_reg; // Outgoing bits
   logic [7:0] snap_reg; // Value handed to the host for this byte
   logic [7:0] ptr_reg; // Byte address pointer
   logic read_dir_reg; // Current transaction is a read
   logic host_ack_reg; // Host acknowledged the last byte
   logic sda_out_reg;
   logic sda_oe_reg;

   // Latched flag registers
   logic [7:0] sig_loss_reg;
   logic [7:0] tx_fault_reg;
   logic [7:0] temp_reg;
   logic [7:0] vcc_reg;
   logic [7:0] rx_power_reg;
   logic init_pending_reg; // Waiting for initialization to finish
   logic irq_n_reg;

   // Bus events seen on the synchronised lines
   wire scl_rise = scl_s2_reg && !scl_s3_reg;
   wire scl_fall = !scl_s2_reg && scl_s3_reg;
   wire start_seen = scl_s2_reg && scl_s3_reg && !sda_s2_reg && sda_s3_reg;
   wire stop_seen = scl_s2_reg && scl_s3_reg && sda_s2_reg && !sda_s3_reg;
   wire addr_match = rx_shift_reg[7:1] == DEVICE_ADDR;
   wire shifting = state_reg == ST_ADDR || state_reg == ST_PTR ||
                   state_reg == ST_WDATA || state_reg == ST_RDATA;

   // Either reset source restarts the block
   wire rst_all = I_RST || !rstn_s2_reg; // R5

   // Clear fires on the host's acknowledge clock, after all 8 bits went out
   wire clear_fire = scl_rise && state_reg == ST_RDATA_ACK; // R16

   // Initialization-complete event, once per reset
   wire init_set = init_pending_reg && I_INIT_DONE; // R12

   // Condition vectors placed at their bit positions
   wire [7:0] set_sig_loss = {I_TX_LOSS, I_RX_LOSS}; // R9
   wire [7:0] set_tx_fault = {4'h0, I_TX_FAULT}; // R10
   wire [7:0] set_temp = {I_TEMP_COND, 3'h0, init_set}; // R11
   wire [7:0] set_vcc = {I_VCC_COND, 4'h0}; // R13
   wire [7:0] set_rx_power = {I_RX_POWER_CH1, I_RX_POWER_CH2}; // R14

   // Read data selection; unimplemented bytes of the field read zero
   wire [7:0] rd_byte =
      (ptr_reg == flag_field_pkg::OFF_SIGNAL_LOSS) ? sig_loss_reg :
      (ptr_reg == flag_field_pkg::OFF_TX_FAULT) ? tx_fault_reg :
      (ptr_reg == flag_field_pkg::OFF_TEMPERATURE) ? temp_reg :
      (ptr_reg == flag_field_pkg::OFF_SUPPLY_VOLTAGE) ? vcc_reg :
      (ptr_reg == flag_field_pkg::OFF_VENDOR) ? I_VENDOR_FLAGS :
      (ptr_reg == flag_field_pkg::OFF_RX_POWER) ? rx_power_reg :
      8'h00; // R1 R2

   // Unmasked flag summary
   wire any_unmasked = |(sig_loss_reg & ~I_MASK_SIGNAL_LOSS) |
                       |(tx_fault_reg & ~I_MASK_TX_FAULT) |
                       |(temp_reg & ~I_MASK_TEMPERATURE) |
                       |(vcc_reg & ~I_MASK_SUPPLY_VOLTAGE) |
                       |(rx_power_reg & ~I_MASK_RX_POWER); // R8

   // Synchronisers; the reset pin chain answers only to the core reset
   always_ff @(posedge I_CORE_CLK) begin
      if (I_RST) begin
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         scl_s3_reg <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         sda_s3_reg <= 1'b1;
         rstn_s1_reg <= 1'b1;
         rstn_s2_reg <= 1'b1;
      end else begin
         scl_s1_reg <= I_SCL;
         scl_s2_reg <= scl_s1_reg;
         scl_s3_reg <= scl_s2_reg;
         sda_s1_reg <= I_SDA;
         sda_s2_reg <= sda_s1_reg;
         sda_s3_reg <= sda_s2_reg;
         rstn_s1_reg <= I_MODULE_RESET_N;
         rstn_s2_reg <= rstn_s1_reg;
      end
   end

   // Bit capture on rising clock edges
   always_ff @(posedge I_CORE_CLK) begin
      if (rst_all || start_seen || stop_seen) begin
         bit_cnt_reg <= 3'h0;
         byte_full_reg <= 1'b0;
         rx_shift_reg <= 8'h00;
         host_ack_reg <= 1'b0;
      end else if (scl_rise) begin
         // Host acknowledge is sampled in the ninth clock of a read byte
         if (state_reg == ST_RDATA_ACK) begin
            host_ack_reg <= !sda_s2_reg;
         end
         if (shifting) begin
            rx_shift_reg <= {rx_shift_reg[6:0], sda_s2_reg};
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            byte_full_reg <= bit_cnt_reg == 3'h7;
         end
      end else if (scl_fall) begin
         byte_full_reg <= 1'b0;
      end
   end

   // Protocol sequencing and line drive; data changes only while SCL is low
   always_ff @(posedge I_CORE_CLK) begin
      if (rst_all) begin
         state_reg <= ST_IDLE;
         ptr_reg <= 8'h00;
         read_dir_reg <= 1'b0;
         tx_shift_reg <= 8'h00;
         snap_reg <= 8'h00;
         sda_out_reg <= 1'b1;
         sda_oe_reg <= 1'b0;
      end else if (start_seen || stop_seen) begin
         // Start or repeated start re-arms; stop releases the bus
         state_reg <= start_seen ? ST_ADDR : ST_IDLE;
         sda_out_reg <= 1'b1;
         sda_oe_reg <= 1'b0;
      end else if (scl_rise && state_reg == ST_RDATA_ACK) begin
         // Byte delivered, move to the next address
         ptr_reg <= ptr_reg + 8'h01;
      end else if (scl_fall) begin
         unique case (state_reg)
            ST_IDLE: begin
               sda_oe_reg <= 1'b0;
            end
            ST_ADDR: begin
               if (byte_full_reg) begin
                  // Acknowledge only our own address
                  state_reg <= addr_match ? ST_ADDR_ACK : ST_IDLE;
                  read_dir_reg <= rx_shift_reg[0];
                  sda_out_reg <= !addr_match;
                  sda_oe_reg <= addr_match;
               end
            end
            ST_ADDR_ACK, ST_RDATA_ACK: begin
               if ((state_reg == ST_ADDR_ACK && read_dir_reg) ||
                   (state_reg == ST_RDATA_ACK && host_ack_reg)) begin
                  // Load and present the first bit of the next byte
                  state_reg <= ST_RDATA;
                  tx_shift_reg <= rd_byte;
                  snap_reg <= rd_byte;
                  sda_out_reg <= rd_byte[7];
                  sda_oe_reg <= !rd_byte[7];
               end else begin
                  // Write continues with the pointer; a not-acknowledge ends the read
                  state_reg <= (state_reg == ST_ADDR_ACK) ? ST_PTR : ST_IDLE;
                  sda_out_reg <= 1'b1;
                  sda_oe_reg <= 1'b0;
               end
            end
            ST_PTR, ST_WDATA: begin
               if (byte_full_reg) begin
                  // Data bytes after the pointer are acknowledged and dropped
                  if (state_reg == ST_PTR) begin
                     ptr_reg <= rx_shift_reg;
                  end
                  state_reg <= ST_PTR_ACK;
                  sda_out_reg <= 1'b0;
                  sda_oe_reg <= 1'b1;
               end
            end
            ST_PTR_ACK: begin
               state_reg <= ST_WDATA;
               sda_out_reg <= 1'b1;
               sda_oe_reg <= 1'b0;
            end
            ST_RDATA: begin
               if (byte_full_reg) begin
                  // Release for the host's acknowledge
                  state_reg <= ST_RDATA_ACK;
                  sda_out_reg <= 1'b1;
                  sda_oe_reg <= 1'b0;
               end else begin
                  tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                  sda_out_reg <= tx_shift_reg[6];
                  sda_oe_reg <= !tx_shift_reg[6];
               end
            end
         endcase
      end
   end

   // Flag latches: set by conditions, cleared by completed reads.
   // A condition still present re-sets its bit in the clearing cycle.
   always_ff @(posedge I_CORE_CLK) begin
      if (rst_all) begin
         sig_loss_reg <= flag_field_pkg::FLAG_RESET; // R2 R5
         tx_fault_reg <= flag_field_pkg::FLAG_RESET;
         temp_reg <= flag_field_pkg::FLAG_RESET;
         vcc_reg <= flag_field_pkg::FLAG_RESET;
         rx_power_reg <= flag_field_pkg::FLAG_RESET;
         init_pending_reg <= 1'b1;
      end else begin
         sig_loss_reg <= latch_next(sig_loss_reg, set_sig_loss,
            clear_for(clear_fire, ptr_reg, flag_field_pkg::OFF_SIGNAL_LOSS, snap_reg),
            flag_field_pkg::IMPL_SIGNAL_LOSS); // R3 R4 R6 R9
         tx_fault_reg <= latch_next(tx_fault_reg, set_tx_fault,
            clear_for(clear_fire, ptr_reg, flag_field_pkg::OFF_TX_FAULT, snap_reg),
            flag_field_pkg::IMPL_TX_FAULT); // R10
         temp_reg <= latch_next(temp_reg, set_temp,
            clear_for(clear_fire, ptr_reg, flag_field_pkg::OFF_TEMPERATURE, snap_reg),
            flag_field_pkg::IMPL_TEMPERATURE); // R11 R12
         vcc_reg <= latch_next(vcc_reg, set_vcc,
            clear_for(clear_fire, ptr_reg, flag_field_pkg::OFF_SUPPLY_VOLTAGE, snap_reg),
            flag_field_pkg::IMPL_SUPPLY_VOLTAGE); // R13
         rx_power_reg <= latch_next(rx_power_reg, set_rx_power,
            clear_for(clear_fire, ptr_reg, flag_field_pkg::OFF_RX_POWER, snap_reg),
            flag_field_pkg::IMPL_RX_POWER); // R14 R16
         // Init-complete fires once per reset
         if (I_INIT_DONE) begin
            init_pending_reg <= 1'b0; // R12
         end
      end
   end

   // Interrupt request, registered from the latched flags
   always_ff @(posedge I_CORE_CLK) begin
      if (rst_all) begin
         irq_n_reg <= 1'b1;
      end else begin
         irq_n_reg <= !any_unmasked; // R15 R8
      end
   end

   // Outputs straight from flip-flops
   assign O_SDA = sda_out_reg;
   assign O_SDA_OE = sda_oe_reg;
   assign O_INTERRUPT_REQUEST_N = irq_n_reg;

endmodule

// file: hdl/flag_field_pkg.sv
// Constants for the latched status flag field and its two-wire read port.
// Assumes a single core clock; offsets are byte addresses on the two-wire bus.
package flag_field_pkg;
   // Bounds of the flag field in the management memory
   localparam logic [7:0] FIELD_FIRST = 8'h03;
   localparam logic [7:0] FIELD_LAST = 8'h15;
   // Byte offsets of the individual registers
   localparam logic [7:0] OFF_SIGNAL_LOSS = 8'h03;
   localparam logic [7:0] OFF_TX_FAULT = 8'h04;
   localparam logic [7:0] OFF_RESERVED_A = 8'h05;
   localparam logic [7:0] OFF_TEMPERATURE = 8'h06;
   localparam logic [7:0] OFF_SUPPLY_VOLTAGE = 8'h07;
   localparam logic [7:0] OFF_VENDOR = 8'h08;
   localparam logic [7:0] OFF_RX_POWER = 8'h09;
   // Implemented bits per register; reserved bits read zero
   localparam logic [7:0] IMPL_SIGNAL_LOSS = 8'hFF;
   localparam logic [7:0] IMPL_TX_FAULT = 8'h0F;
   localparam logic [7:0] IMPL_TEMPERATURE = 8'hF1;
   localparam logic [7:0] IMPL_SUPPLY_VOLTAGE = 8'hF0;
   localparam logic [7:0] IMPL_RX_POWER = 8'hFF;
   // Field positions inside the temperature byte
   localparam int INIT_DONE_BIT = 0;
   // Reset value of every latched flag
   localparam logic [7:0] FLAG_RESET = 8'h00;
   // Default 7-bit two-wire device address
   localparam logic [6:0] DEVICE_ADDR_DEFAULT = 7'h50;
endpackage

// file: dv/latched_flag_field_sva.sv
// Checker for the flag field: interrupt level, reset pin, data line drive.
// Assumes bind to the top module; everything sits on the core clock.
`timescale 1ns/1ps
module latched_flag_field_sva (
   input wire logic I_CORE_CLK,
   input wire logic I_RST,
   input wire logic I_MODULE_RESET_N,
   input wire logic I_SCL,
   input wire logic O_SDA,
   input wire logic O_SDA_OE,
   input wire logic [3:0] I_TX_LOSS,
   input wire logic [3:0] I_RX_LOSS,
   input wire logic [3:0] I_TX_FAULT,
   input wire logic [3:0] I_TEMP_COND,
   input wire logic [3:0] I_VCC_COND,
   input wire logic [3:0] I_RX_POWER_CH1,
   input wire logic [3:0] I_RX_POWER_CH2,
   input wire logic I_INIT_DONE,
   input wire logic [7:0] I_MASK_SIGNAL_LOSS,
   input wire logic [7:0] I_MASK_TX_FAULT,
   input wire logic [7:0] I_MASK_TEMPERATURE,
   input wire logic [7:0] I_MASK_SUPPLY_VOLTAGE,
   input wire logic [7:0] I_MASK_RX_POWER,
   input wire logic O_INTERRUPT_REQUEST_N
);
   default clocking @(posedge I_CORE_CLK); endclocking
   default disable iff (I_RST);
   logic [2:0] pin_cnt; // High run of the reset pin
   logic [2:0] scl_cnt; // High run of the clock line
   logic [39:0] mask_prev; // Masks one cycle back
   wire logic [39:0] masks = {I_MASK_SIGNAL_LOSS, I_MASK_TX_FAULT, I_MASK_TEMPERATURE, I_MASK_SUPPLY_VOLTAGE,
      I_MASK_RX_POWER};
   wire logic mask_chg = (masks != mask_prev);
   // Unmasked causes; init left out, it fires once per reset only
   wire logic live = (|({I_TX_LOSS, I_RX_LOSS} & ~I_MASK_SIGNAL_LOSS)) || (|(I_TX_FAULT & ~I_MASK_TX_FAULT[3:0]))
      || (|(I_TEMP_COND & ~I_MASK_TEMPERATURE[7:4])) || (|(I_VCC_COND & ~I_MASK_SUPPLY_VOLTAGE[7:4]))
      || (|({I_RX_POWER_CH1, I_RX_POWER_CH2} & ~I_MASK_RX_POWER));
   wire logic any_cond = |{I_TX_LOSS, I_RX_LOSS, I_TX_FAULT, I_TEMP_COND, I_VCC_COND, I_RX_POWER_CH1,
      I_RX_POWER_CH2, I_INIT_DONE};
   // Saturating run counters; the pin needs its sync chain filled first
   always_ff @(posedge I_CORE_CLK) begin
      mask_prev <= masks;
      if (I_RST || !I_MODULE_RESET_N) begin
         pin_cnt <= 3'h0;
      end else begin
         pin_cnt <= pin_cnt + 3'(pin_cnt != 3'h7);
      end
      // Cleared in core reset so the run never starts unknown
      if (I_RST || !I_SCL) begin
         scl_cnt <= 3'h0;
      end else begin
         scl_cnt <= scl_cnt + 3'(scl_cnt != 3'h7);
      end
   end
   reset_quiet_a: assert property ($fell(I_RST) |-> O_INTERRUPT_REQUEST_N && !O_SDA_OE)
      else $error("outputs busy at reset release");
   pin_clear_a: assert property (!I_MODULE_RESET_N [*5] |=> O_INTERRUPT_REQUEST_N)
      else $error("interrupt held through pin reset");
   pin_port_a: assert property (!I_MODULE_RESET_N [*5] |=> !O_SDA_OE)
      else $error("data line driven in pin reset");
   pin_sda_a: assert property (!I_MODULE_RESET_N [*5] |=> O_SDA)
      else $error("data bit not released in pin reset");
   irq_raise_a: assert property (live && pin_cnt > 3'h5 ##1 !mask_chg |-> ##1 !O_INTERRUPT_REQUEST_N)
      else $error("unmasked event raised no interrupt");
   irq_cause_a: assert property ($fell(O_INTERRUPT_REQUEST_N) |-> $past(any_cond, 2) || $past(mask_chg))
      else $error("interrupt without cause");
   // Pin reset legally drops the request, so the pin must have been high a while
   irq_hold_a: assert property (!O_INTERRUPT_REQUEST_N && !mask_chg && scl_cnt > 3'h5 && pin_cnt > 3'h5
      |=> !O_INTERRUPT_REQUEST_N)
      else $error("interrupt dropped without read");
   mask_silent_a: assert property (&masks |=> O_INTERRUPT_REQUEST_N)
      else $error("masked flags raised interrupt");
   cover property ($fell(O_INTERRUPT_REQUEST_N));
   cover property ($rose(O_SDA_OE));
   cover property ($fell(I_MODULE_RESET_N));
endmodule
bind latched_flag_field latched_flag_field_sva chk (.I_CORE_CLK, .I_RST, .I_MODULE_RESET_N, .I_SCL, .O_SDA,
   .O_SDA_OE, .I_TX_LOSS, .I_RX_LOSS, .I_TX_FAULT, .I_TEMP_COND, .I_VCC_COND, .I_RX_POWER_CH1, .I_RX_POWER_CH2,
   .I_INIT_DONE, .I_MASK_SIGNAL_LOSS, .I_MASK_TX_FAULT, .I_MASK_TEMPERATURE, .I_MASK_SUPPLY_VOLTAGE,
   .I_MASK_RX_POWER, .O_INTERRUPT_REQUEST_N);

// file: dv/twi_host.sv
// Two-wire host model: 80 ns bit period, open drain data with pull-up.
// Assumes the device pulls the line low while its enable is high.
`timescale 1ns/1ps
module twi_host (
   input wire logic i_clk,
   input wire logic i_dev_oe,
   output logic o_scl,
   output logic o_sda
);
   logic sda_drv; // Host side: 1 releases the line
   assign o_sda = sda_drv & ~i_dev_oe; // Wired-AND, pulled up
   initial begin
      o_scl = 1'b1;
      sda_drv = 1'b1;
   end
   // Quarter bit; clock stands high outside frames
   task automatic q();
      repeat (2) @(posedge i_clk);
   endtask
   // Start or repeated start; half a bit first so the device lets go of its ack
   task automatic start();
      sda_drv <= 1'b1;
      q();
      q();
      o_scl <= 1'b1;
      q();
      sda_drv <= 1'b0;
      q();
      o_scl <= 1'b0;
   endtask
   task automatic stop();
      q();
      sda_drv <= 1'b0;
      q();
      o_scl <= 1'b1;
      q();
      sda_drv <= 1'b1;
      q();
   endtask
   // Data moves mid-low, sampled mid-high
   task automatic bit_io(input logic b, output logic r);
      q();
      sda_drv <= b;
      q();
      o_scl <= 1'b1;
      q();
      r = o_sda;
      q();
      o_scl <= 1'b0;
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
   endtask
endmodule

// file: dv/test_latched_flag_field.sv
// Bench for the flag field: init flag, random events, persistence, pin reset.
// Assumes the host model on the two-wire port and the bound checker.
`timescale 1ns/1ps
module test_latched_flag_field;
   logic clk, rst, pin_n, init_done, scl, sda, oe, irq_n, pend;
   logic [3:0] txl, rxl, txf, tmp, vcc, p1, p2;
   logic [7:0] vend, m3, m4, m6, m7, m9;
   logic [15:0] lfsr; // Random source
   int model [3:21]; // Expected flag bytes
   int failures, n_tests;
   twi_host host (.i_clk(clk), .i_dev_oe(oe), .o_scl(scl), .o_sda(sda));
   latched_flag_field uut (.I_CORE_CLK(clk), .I_RST(rst), .I_MODULE_RESET_N(pin_n), .I_SCL(scl), .I_SDA(sda),
      .O_SDA(), .O_SDA_OE(oe), .I_TX_LOSS(txl), .I_RX_LOSS(rxl), .I_TX_FAULT(txf), .I_TEMP_COND(tmp),
      .I_VCC_COND(vcc), .I_RX_POWER_CH1(p1), .I_RX_POWER_CH2(p2), .I_INIT_DONE(init_done), .I_VENDOR_FLAGS(vend),
      .I_MASK_SIGNAL_LOSS(m3), .I_MASK_TX_FAULT(m4), .I_MASK_TEMPERATURE(m6), .I_MASK_SUPPLY_VOLTAGE(m7),
      .I_MASK_RX_POWER(m9), .O_INTERRUPT_REQUEST_N(irq_n));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Model latches at the falling edge, after the rising-edge drives land
   always @(negedge clk) begin
      if (rst || !pin_n) begin
         model = '{default: 0};
         pend = 1'b1; // Either reset rearms the init flag
      end else begin
         model[3] |= {txl, rxl};
         model[4] |= txf;
         model[6] |= {tmp, 3'h0, pend & init_done};
         model[7] |= {vcc, 4'h0};
         model[9] |= {p1, p2};
         pend = pend & ~init_done;
      end
   end
   function automatic logic [7:0] rnd();
      for (int i = 0; i < 8; i++) begin
         lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      end
      return lfsr[7:0];
   endfunction
   function automatic logic [7:0] irq_exp();
      return {7'h0, !(|((8'(model[3]) & ~m3) | (8'(model[4]) & ~m4) | (8'(model[6]) & ~m6)
         | (8'(model[7]) & ~m7) | (8'(model[9]) & ~m9)))};
   endfunction
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Pointer write, repeated start, n bytes read; last one refused by the host
   task automatic rd(input int a, input int n);
      logic [7:0] r, exp;
      logic k;
      host.start();
      host.xfer({flag_field_pkg::DEVICE_ADDR_DEFAULT, 1'b0}, r);
      host.bit_io(1'b1, k);
      host.xfer(8'(a), r);
      host.bit_io(1'b1, k);
      host.start();
      host.xfer({flag_field_pkg::DEVICE_ADDR_DEFAULT, 1'b1}, r);
      host.bit_io(1'b1, k);
      chk("ack", 8'h00, {7'h0, k});
      for (int i = 0; i < n; i++) begin
         // Expected byte fixed before the device snapshots it; later events stay latched
         exp = (a + i == 8) ? vend : 8'(model[a + i]);
         host.xfer(8'hFF, r);
         chk("flag byte", exp, r);
         model[a + i] &= ~int'(exp);
         host.bit_io(i == n - 1, k);
      end
      host.stop();
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Watchdog well past the expected run of about 100 us
   initial begin
      #500000;
      failures++;
      end_of_test();
   end
   initial begin
      {rst, pin_n, init_done, pend} = 4'hF;
      {txl, rxl, txf, tmp, vcc, p1, p2} = 28'h0;
      {vend, m3, m4, m6, m7, m9} = 48'h0;
      lfsr = 16'h4956;
      failures = 0;
      n_tests = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      init_done <= 1'b0;
      chk("irq", irq_exp(), {7'h0, irq_n});
      rd(3, 19);
      rd(6, 1);
      $display("test init flag done");
      // One-cycle events with random masks, then read and clear
      for (int t = 0; t < 8; t++) begin
         {txl, rxl} <= rnd();
         {txf, tmp} <= rnd();
         {vcc, p1} <= rnd();
         p2 <= 4'(rnd());
         {vend, m3, m4} <= {rnd(), rnd(), rnd()};
         {m6, m7, m9} <= {rnd(), rnd(), rnd()};
         @(posedge clk);
         {txl, rxl, txf, tmp, vcc, p1, p2} <= 28'h0;
         repeat (5) @(posedge clk);
         chk("irq", irq_exp(), {7'h0, irq_n});
         rd(3, 7);
         repeat (5) @(posedge clk);
         chk("irq", irq_exp(), {7'h0, irq_n});
      end
      $display("test random events done");
      {m3, m4, m6, m7, m9} <= {40{1'b1}};
      txf <= 4'h3;
      repeat (5) @(posedge clk);
      chk("irq", irq_exp(), {7'h0, irq_n});
      rd(4, 1);
      rd(4, 1);
      txf <= 4'h0;
      rd(4, 2);
      rd(4, 1);
      $display("test persistent fault done");
      // Event in mid-byte, after the snapshot: that byte's clear must spare it
      fork
         rd(3, 1);
         begin
            repeat (260) @(posedge clk);
            rxl <= 4'h2;
            @(posedge clk);
            rxl <= 4'h0;
         end
      join
      rd(3, 1);
      $display("test event during read done");
      {m3, m4, m6, m7, m9} <= 40'h0;
      rxl <= 4'hF;
      @(posedge clk);
      rxl <= 4'h0;
      pin_n <= 1'b0;
      repeat (6) @(posedge clk);
      pin_n <= 1'b1;
      repeat (8) @(posedge clk);
      chk("irq", irq_exp(), {7'h0, irq_n});
      rd(3, 1);
      $display("test pin reset done");
      end_of_test();
   end
endmodule
